// ### design/nbcdb_host.sv
/*
  host controller that drives a raw parallel flash bus cycle by cycle.
  assumes io_in and ready_busy_n are synchronous to mclk; the bench
  resolves the shared data wire from pins.io_oe.
*/
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - address cycle: select low, read strobe high, address latch high, write strobe latches.
// - command cycle: select low, read strobe high, command latch high, write strobe latches.
// - program/erase commands, their addresses and data input need write protect high.
// - data in with both latches low; data out pulses read strobe, write strobe high.
// - no more than 4 partial programs to one page between erases; counted only for the last page programmed, cleared by any erase.
// - at least 70 ns from last address cycle to first data input.
// - while busy only reset and status read commands may be issued.
module nbcdb_host #(
  parameter int unsigned COL_BYTES = 2,
  parameter int unsigned ROW_BYTES = 2,
  parameter int unsigned BUSY_TIMEOUT_CYCLES = nbcdb_pkg::BUSY_TIMEOUT_CYC,
  parameter int unsigned PARTIAL_LIMIT = nbcdb_pkg::PARTIAL_PROGRAM_LIMIT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire nbcdb_pkg::nbcdb_req_type req,
  output logic req_ready,
  input wire logic write_allow,
  output logic resp_valid,
  output nbcdb_pkg::nbcdb_resp_type resp,
  output nbcdb_pkg::nbcdb_pins_type pins,
  input wire logic [nbcdb_pkg::DATA_W-1:0] io_in,
  input wire logic ready_busy_n
);
  import nbcdb_pkg::*;

  localparam int unsigned TW = $clog2(BUSY_TIMEOUT_CYCLES + 1);
  localparam int unsigned CW = $clog2(PARTIAL_LIMIT + 1);
  localparam int unsigned KW = ROW_BYTES * DATA_W;
  localparam int unsigned AW = $clog2(COL_BYTES + ROW_BYTES + 1);

  typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_SETUP, ST_STROBE, ST_HOLD, ST_TWB,
                            ST_BUSY} nbcdb_state_type;
  typedef enum logic [1:0] {LK_NONE, LK_ADDR, LK_WRITE, LK_READ} nbcdb_last_type;

  nbcdb_state_type state_ff, nxt_state;
  nbcdb_last_type last_ff;
  nbcdb_req_type cur_ff;
  logic pend_ff, wmode_ff, wseq_ff, wp_n_ff;
  logic [CW-1:0] prog_cnt_ff;
  logic [KW-1:0] page_key_ff, row_acc_ff;
  logic [AW-1:0] addr_idx_ff;
  logic resp_valid_ff;
  nbcdb_resp_type resp_ff;
  logic tmr_load, tmr_zero;
  logic [TW-1:0] tmr_val;
  logic take, is_cmd, wmode_cmd, need_wp, confirm, refuse;
  nbcdb_err_type refuse_err;

  // ----------------------------------------
  // request classification
  // ----------------------------------------
  assign req_ready = clk_en && (state_ff == ST_IDLE) && (write_allow == wp_n_ff);
  assign take = req_valid && req_ready;
  assign is_cmd = (req.op == OP_CMD);
  assign wmode_cmd = is_cmd && (req.data == CMD_PROG_SETUP || req.data == CMD_PROG_CONFIRM ||
    req.data == CMD_CACHE_PROG_CONFIRM || req.data == CMD_RANDOM_DATA_IN ||
    req.data == CMD_ERASE_SETUP || req.data == CMD_ERASE_CONFIRM);
  assign need_wp = wmode_cmd || (req.op == OP_DATA_IN) || (req.op == OP_ADDR && wseq_ff);
  assign confirm = is_cmd && (req.data == CMD_PROG_CONFIRM || req.data == CMD_CACHE_PROG_CONFIRM);

  always_comb begin
    refuse = 1'b1;
    refuse_err = ERR_NONE;
    if (is_cmd && !ready_busy_n && req.data != CMD_RESET && req.data != CMD_STATUS) begin
      refuse_err = ERR_BUSY;
    end else if (need_wp && !wp_n_ff) begin
      refuse_err = ERR_PROTECT;
    end else if (confirm && page_key_ff == row_acc_ff && prog_cnt_ff >= CW'(PARTIAL_LIMIT)) begin
      refuse_err = ERR_LIMIT;
    end else begin
      refuse = 1'b0;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_ff)
      ST_IDLE: begin
        if (write_allow != wp_n_ff) begin
          tmr_load = 1'b1;
          tmr_val = TW'(WP_TO_WE_HIGH_CYC - 1);
          nxt_state = ST_GAP;
        end else if (take && !refuse) begin
          if (req.op == OP_WAIT_READY) begin
            tmr_load = 1'b1;
            tmr_val = TW'(WE_HIGH_TO_BUSY_CYC - 1);
            nxt_state = ST_TWB;
          end else if (req.op == OP_DATA_IN && last_ff == LK_ADDR) begin
            tmr_load = 1'b1;
            tmr_val = TW'(ADDRESS_TO_DATA_GAP_CYC - 1);
            nxt_state = ST_GAP;
          end else if (req.op == OP_DATA_OUT && last_ff != LK_READ && last_ff != LK_NONE) begin
            tmr_load = 1'b1;
            tmr_val = TW'(WE_HIGH_TO_RE_LOW_CYC - 1);
            nxt_state = ST_GAP;
          end else if (req.op != OP_DATA_OUT && last_ff == LK_READ) begin
            tmr_load = 1'b1;
            tmr_val = TW'(RE_HIGH_TO_WE_LOW_CYC - 1);
            nxt_state = ST_GAP;
          end else begin
            nxt_state = ST_SETUP;
          end
        end
      end
      ST_GAP: begin
        if (tmr_zero) begin
          nxt_state = pend_ff ? ST_SETUP : ST_IDLE;
        end
      end
      ST_SETUP: nxt_state = ST_STROBE;
      ST_STROBE: nxt_state = ST_HOLD;
      ST_HOLD: nxt_state = ST_IDLE;
      ST_TWB: begin
        if (tmr_zero) begin
          tmr_load = 1'b1;
          tmr_val = TW'(BUSY_TIMEOUT_CYCLES - 1);
          nxt_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (ready_busy_n || tmr_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  nbcdb_timer #(.W(TW)) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .load(tmr_load),
    .load_val(tmr_val),
    .zero(tmr_zero)
  );

  // ----------------------------------------
  // current request and write protect level
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '{op: OP_CMD, data: '0};
      pend_ff <= 1'b0;
      wmode_ff <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == ST_IDLE) begin
        pend_ff <= take && !refuse;
        if (take) begin
          cur_ff <= req;
          wmode_ff <= need_wp;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_n_ff <= 1'b0;
    end else if (clk_en && state_ff == ST_IDLE) begin
      wp_n_ff <= write_allow;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_ff <= LK_NONE;
    end else if (clk_en && state_ff == ST_HOLD) begin
      case (cur_ff.op)
        OP_ADDR: last_ff <= LK_ADDR;
        OP_DATA_OUT: last_ff <= LK_READ;
        default: last_ff <= LK_WRITE;
      endcase
    end
  end

  // ----------------------------------------
  // partial program tracking for the last page programmed
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wseq_ff <= 1'b0;
      addr_idx_ff <= '0;
      row_acc_ff <= '0;
    end else if (clk_en && take && !refuse) begin
      if (is_cmd) begin
        addr_idx_ff <= '0;
        wseq_ff <= (req.data == CMD_PROG_SETUP || req.data == CMD_ERASE_SETUP ||
          req.data == CMD_RANDOM_DATA_IN);
        if (req.data == CMD_PROG_SETUP) begin
          row_acc_ff <= '0;
        end
      end else if (req.op == OP_ADDR) begin
        if (addr_idx_ff != AW'(COL_BYTES + ROW_BYTES)) begin
          addr_idx_ff <= addr_idx_ff + 1'b1;
        end
        if (addr_idx_ff >= AW'(COL_BYTES) && addr_idx_ff < AW'(COL_BYTES + ROW_BYTES)) begin
          row_acc_ff <= {row_acc_ff[KW-DATA_W-1:0], req.data};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prog_cnt_ff <= '0;
      page_key_ff <= '0;
    end else if (clk_en && take && !refuse && is_cmd) begin
      if (req.data == CMD_ERASE_CONFIRM) begin
        prog_cnt_ff <= '0;
      end else if (confirm) begin
        page_key_ff <= row_acc_ff;
        prog_cnt_ff <= (page_key_ff == row_acc_ff) ? prog_cnt_ff + 1'b1 : CW'(1);
      end
    end
  end

  // ----------------------------------------
  // answers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      resp_valid_ff <= 1'b0;
      resp_ff <= '{err: ERR_NONE, data: '0};
    end else if (clk_en) begin
      resp_valid_ff <= 1'b0;
      if (state_ff == ST_IDLE && take && refuse) begin
        resp_valid_ff <= 1'b1;
        resp_ff <= '{err: refuse_err, data: '0};
      end else if (state_ff == ST_STROBE && cur_ff.op == OP_DATA_OUT) begin
        resp_ff <= '{err: ERR_NONE, data: io_in};
      end else if (state_ff == ST_HOLD) begin
        resp_valid_ff <= 1'b1;
        if (cur_ff.op != OP_DATA_OUT) begin
          resp_ff <= '{err: ERR_NONE, data: '0};
        end
      end else if (state_ff == ST_BUSY && (ready_busy_n || tmr_zero)) begin
        resp_valid_ff <= 1'b1;
        resp_ff <= '{err: ready_busy_n ? ERR_NONE : ERR_TIMEOUT, data: '0};
      end
    end
  end

  assign resp_valid = resp_valid_ff;
  assign resp = resp_ff;

  // ----------------------------------------
  // pin levels decoded from registered state
  // ----------------------------------------
  logic active, strobe;
  assign active = (state_ff == ST_SETUP) || (state_ff == ST_STROBE) || (state_ff == ST_HOLD);
  assign strobe = (state_ff == ST_STROBE);
  always_comb begin
    pins.chip_select_n = !active;
    pins.cmd_latch_enable = active && cur_ff.op == OP_CMD;
    pins.addr_latch_enable = active && cur_ff.op == OP_ADDR;
    pins.write_strobe_n = !(strobe && cur_ff.op != OP_DATA_OUT);
    pins.read_strobe_n = !(strobe && cur_ff.op == OP_DATA_OUT);
    pins.write_protect_n = wp_n_ff;
    pins.io_oe = active && cur_ff.op != OP_DATA_OUT;
    pins.io_out = cur_ff.data;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [3:0] addr_gap_cnt;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_gap_cnt <= '0;
    end else if (clk_en) begin
      if (!pins.write_strobe_n) begin
        addr_gap_cnt <= '0;
      end else if (addr_gap_cnt != 4'hf) begin
        addr_gap_cnt <= addr_gap_cnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_busy_cmd;
    clk_en && take && is_cmd && !ready_busy_n && req.data != CMD_RESET &&
      req.data != CMD_STATUS;
  endsequence
  sequence s_no_strobe;
    pins.write_strobe_n [*3];
  endsequence

  a_addr_levels: assert property (!pins.write_strobe_n && pins.addr_latch_enable |->
    !pins.chip_select_n && pins.read_strobe_n && !pins.cmd_latch_enable)
    else $error("address cycle levels wrong");
  a_cmd_levels: assert property (!pins.write_strobe_n && pins.cmd_latch_enable |->
    !pins.chip_select_n && pins.read_strobe_n && !pins.addr_latch_enable &&
    $stable(pins.io_out))
    else $error("command cycle levels wrong");
  a_write_protect_high: assert property ($fell(pins.write_strobe_n) && wmode_ff |->
    pins.write_protect_n && $past(pins.write_protect_n, 3))
    else $error("write-mode cycle without write protect high");
  a_data_out_levels: assert property (!pins.read_strobe_n |-> pins.write_strobe_n &&
    !pins.cmd_latch_enable && !pins.addr_latch_enable && !pins.chip_select_n && !pins.io_oe)
    else $error("data output cycle levels wrong");
  a_partial_limit: assert property (prog_cnt_ff <= CW'(PARTIAL_LIMIT))
    else $error("partial program count over limit");
  a_addr_data_gap: assert property ($fell(pins.write_strobe_n) &&
    !pins.cmd_latch_enable && !pins.addr_latch_enable && last_ff == LK_ADDR |->
    addr_gap_cnt >= 4'(ADDRESS_TO_DATA_GAP_CYC))
    else $error("data input too soon after address");
  a_busy_refuse: assert property (s_busy_cmd |=> resp_valid && resp.err == ERR_BUSY
    ##0 s_no_strobe)
    else $error("command issued while busy");

endmodule

`default_nettype wire

// ### design/nbcdb_pkg.sv
/*
  shared constants and carriers for the flash bus host controller.
  assumes a 25 MHz mclk and an 8-bit flash data bus.
*/
`default_nettype none

package nbcdb_pkg;

  // ----------------------------------------
  // clock and data width
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG_CONFIRM = 8'h15;
  localparam logic [7:0] CMD_RANDOM_DATA_IN = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;

  // ----------------------------------------
  // bus timing, least times round up
  // ----------------------------------------
  localparam int unsigned ADDRESS_TO_DATA_GAP_NS = 70;
  localparam int unsigned WE_HIGH_TO_RE_LOW_NS = 80;
  localparam int unsigned RE_HIGH_TO_WE_LOW_NS = 60;
  localparam int unsigned WP_TO_WE_HIGH_NS = 100;
  localparam int unsigned WE_HIGH_TO_BUSY_NS = 60;
  localparam int unsigned ADDRESS_TO_DATA_GAP_CYC =
    (ADDRESS_TO_DATA_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_HIGH_TO_RE_LOW_CYC =
    (WE_HIGH_TO_RE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RE_HIGH_TO_WE_LOW_CYC =
    (RE_HIGH_TO_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WP_TO_WE_HIGH_CYC =
    (WP_TO_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_HIGH_TO_BUSY_CYC =
    (WE_HIGH_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // longest busy (block erase) bounds the ready wait
  localparam int unsigned BUSY_TIMEOUT_US = 3500;
  localparam int unsigned BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PARTIAL_PROGRAM_LIMIT = 4;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef enum logic [2:0] {OP_CMD, OP_ADDR, OP_DATA_IN, OP_DATA_OUT, OP_WAIT_READY} nbcdb_op_type;
  typedef enum logic [2:0] {ERR_NONE, ERR_BUSY, ERR_PROTECT, ERR_LIMIT, ERR_TIMEOUT} nbcdb_err_type;

  typedef struct packed {
    nbcdb_op_type op;
    logic [DATA_W-1:0] data;
  } nbcdb_req_type;

  typedef struct packed {
    nbcdb_err_type err;
    logic [DATA_W-1:0] data;
  } nbcdb_resp_type;

  typedef struct packed {
    logic chip_select_n;
    logic cmd_latch_enable;
    logic addr_latch_enable;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_protect_n;
    logic io_oe;
    logic [DATA_W-1:0] io_out;
  } nbcdb_pins_type;

endpackage

`default_nettype wire

// ### design/nbcdb_timer.sv
/*
  loadable down-counter used for bus gaps and busy waits.
  assumes load and clk_en come from the same mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module nbcdb_timer #(
  parameter int unsigned W = 17
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);

  logic [W-1:0] count_ff;

  // ----------------------------------------
  // count down, stop at zero
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= '0;
    end else if (clk_en) begin
      if (load) begin
        count_ff <= load_val;
      end else if (count_ff != '0) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  assign zero = (count_ff == '0);

endmodule

`default_nettype wire

// ### testbench/nbcdb_flash_model.sv
/*
  behavioural flash device facing the host pins, with busy timing.
  assumes pins and the resolved data wire are sampled on mclk.
*/
`timescale 1ns/100ps
`default_nettype none

module nbcdb_flash_model #(
  parameter int unsigned PROG_CYC = 60,
  parameter int unsigned READ_CYC = 30,
  parameter int unsigned RST_CYC = 20,
  parameter int unsigned PBSY_CYC = 8,
  parameter int unsigned CBSY_CYC = 10,
  parameter int unsigned RCBSY_CYC = 12,
  parameter int unsigned FEAT_CYC = 2,
  parameter int unsigned OBSY_CYC = 15,
  parameter logic [15:0] PROT_ROW = 16'hbeef,
  parameter logic [15:0] OTP_ROW = 16'h0077
) (
  input wire logic mclk,
  input wire nbcdb_pkg::nbcdb_pins_type pins,
  input wire logic [7:0] bus,
  output logic [7:0] dev_io,
  output logic ready_busy_n
);
  import nbcdb_pkg::*;
  logic prev_we = 1'b1;
  logic rejected = 1'b0;
  logic wr_busy = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] last_din = 8'h00;
  logic [31:0] addr_q = '0;
  int busy_cnt = 0;
  int n_cmds = 0;
  int cyc = 0;
  int addr_cyc = 0;
  int din_cyc = 0;
  logic stb;

  // ----------------------------------------
  // cycle decode and busy timing
  // ----------------------------------------
  assign stb = !prev_we && pins.write_strobe_n && !pins.chip_select_n;
  assign ready_busy_n = (busy_cnt == 0);
  assign dev_io = (!pins.chip_select_n && !pins.read_strobe_n) ?
    {!rejected, ready_busy_n, ready_busy_n, 5'h00} : ~last_q;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    last_q <= dev_io;
    prev_we <= pins.write_strobe_n;
    if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
    end
    if (!pins.write_protect_n && wr_busy) begin
      busy_cnt <= 0;
    end
    if (stb && pins.cmd_latch_enable &&
        (ready_busy_n || bus == 8'hff || bus == 8'h70)) begin
      last_cmd <= bus;
      n_cmds <= n_cmds + 1;
      wr_busy <= 1'b0;
      if (bus == 8'hff) begin
        busy_cnt <= RST_CYC;
        rejected <= 1'b0;
      end
      if (bus == 8'h30) begin
        busy_cnt <= READ_CYC;
      end
      if (bus == 8'h31) begin
        busy_cnt <= RCBSY_CYC;
      end
      if (bus == 8'hef || bus == 8'hee) begin
        busy_cnt <= FEAT_CYC;
      end
      if ((bus == 8'h10 || bus == 8'h15 || bus == 8'hd0) && pins.write_protect_n) begin
        rejected <= (addr_q[15:0] == PROT_ROW);
        wr_busy <= 1'b1;
        if (addr_q[15:0] == PROT_ROW) begin
          busy_cnt <= PBSY_CYC;
        end else if (addr_q[15:0] == OTP_ROW) begin
          busy_cnt <= OBSY_CYC;
        end else if (bus == 8'h15) begin
          busy_cnt <= CBSY_CYC;
        end else begin
          busy_cnt <= PROG_CYC;
        end
      end
    end
    if (stb && pins.addr_latch_enable) begin
      addr_q <= {addr_q[23:0], bus};
      addr_cyc <= cyc;
    end
    if (stb && !pins.cmd_latch_enable && !pins.addr_latch_enable) begin
      last_din <= bus;
      din_cyc <= cyc;
    end
  end
endmodule

`default_nettype wire

// ### testbench/nbcdb_host_tb_top.sv
/*
  scenario bench for the flash bus host controller.
  assumes the flash model answers on the resolved data wire.
*/
`timescale 1ns/100ps
`default_nettype none

module nbcdb_host_tb_top;
  import nbcdb_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  nbcdb_req_type req = '0;
  logic req_ready;
  logic write_allow = 1'b0;
  logic resp_valid;
  nbcdb_resp_type resp;
  nbcdb_resp_type last_r;
  nbcdb_pins_type pins;
  wire logic [7:0] io_in;
  logic [7:0] dev_io;
  logic ready_busy_n;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  assign io_in = pins.io_oe ? pins.io_out : dev_io;

  nbcdb_host #(.BUSY_TIMEOUT_CYCLES(200)) uut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .write_allow(write_allow),
    .resp_valid(resp_valid), .resp(resp), .pins(pins), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nbcdb_flash_model dev (.mclk(mclk), .pins(pins), .bus(io_in), .dev_io(dev_io),
    .ready_busy_n(ready_busy_n));

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic results;
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_err(input nbcdb_err_type g, input nbcdb_err_type e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: err %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: value %h expected %h", $time, g, e);
    end
  endtask

  task automatic ex(input nbcdb_op_type o, input logic [7:0] d, input nbcdb_err_type e);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{op: o, data: d};
    do begin
      @(negedge mclk);
    end while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
    do begin
      @(negedge mclk);
    end while (resp_valid !== 1'b1);
    last_r = resp;
    chk_err(last_r.err, e);
  endtask

  task automatic prog(input logic [15:0] row, input nbcdb_err_type e);
    ex(OP_CMD, CMD_PROG_SETUP, ERR_NONE);
    ex(OP_ADDR, 8'h00, ERR_NONE);
    ex(OP_ADDR, 8'h00, ERR_NONE);
    ex(OP_ADDR, row[15:8], ERR_NONE);
    ex(OP_ADDR, row[7:0], ERR_NONE);
    ex(OP_DATA_IN, 8'ha5, ERR_NONE);
    ex(OP_CMD, CMD_PROG_CONFIRM, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_wp_low;
    int n;
    chk_val(16'(pins.chip_select_n), 16'h0001);
    chk_val(16'(pins.write_protect_n), 16'h0000);
    n = dev.n_cmds;
    ex(OP_CMD, CMD_PROG_SETUP, ERR_PROTECT);
    ex(OP_DATA_IN, 8'h11, ERR_PROTECT);
    chk_val(16'(dev.n_cmds), 16'(n));
    ex(OP_CMD, CMD_STATUS, ERR_NONE);
    ex(OP_ADDR, 8'h3c, ERR_NONE);
    chk_val(16'(dev.addr_q[7:0]), 16'h003c);
    chk_val(16'(dev.last_cmd), 16'(CMD_STATUS));
  endtask

  task automatic t_program;
    @(posedge mclk);
    write_allow <= 1'b1;
    prog(16'h1234, ERR_NONE);
    chk_val(dev.addr_q[15:0], 16'h1234);
    chk_val(16'(dev.last_din), 16'h00a5);
    chk_val(16'((dev.din_cyc - dev.addr_cyc) * CLK_PERIOD_NS >=
      ADDRESS_TO_DATA_GAP_NS), 16'h0001);
    ex(OP_CMD, CMD_PROG_SETUP, ERR_BUSY);
    ex(OP_CMD, CMD_STATUS, ERR_NONE);
    ex(OP_DATA_OUT, 8'h00, ERR_NONE);
    chk_val(16'(last_r.data), 16'h0080);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    chk_val(16'(ready_busy_n), 16'h0001);
  endtask

  task automatic t_limit;
    for (int i = 0; i < 4; i++) begin
      prog(16'h1234, i < 3 ? ERR_NONE : ERR_LIMIT);
      ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    end
    ex(OP_CMD, CMD_ERASE_SETUP, ERR_NONE);
    ex(OP_ADDR, 8'h12, ERR_NONE);
    ex(OP_ADDR, 8'h34, ERR_NONE);
    ex(OP_CMD, CMD_ERASE_CONFIRM, ERR_NONE);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    prog(16'h1234, ERR_NONE);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
  endtask

  task automatic t_prot_block;
    prog(16'hbeef, ERR_NONE);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    ex(OP_CMD, CMD_STATUS, ERR_NONE);
    ex(OP_DATA_OUT, 8'h00, ERR_NONE);
    chk_val(16'(last_r.data), 16'h0060);
  endtask

  task automatic t_reset_busy;
    prog(16'h0042, ERR_NONE);
    ex(OP_CMD, CMD_RESET, ERR_NONE);
    chk_val(16'(dev.last_cmd), 16'(CMD_RESET));
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    ex(OP_CMD, CMD_STATUS, ERR_NONE);
    ex(OP_DATA_OUT, 8'h00, ERR_NONE);
    chk_val(16'(last_r.data), 16'h00e0);
  endtask

  task automatic t_busy_kinds;
    @(posedge mclk);
    clk_en <= 1'b0;
    @(negedge mclk);
    chk_val(16'(req_ready), 16'h0000);
    @(posedge mclk);
    clk_en <= 1'b1;
    ex(OP_CMD, 8'hef, ERR_NONE);
    chk_val(16'(ready_busy_n), 16'h0000);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    ex(OP_CMD, 8'h31, ERR_NONE);
    chk_val(16'(ready_busy_n), 16'h0000);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    ex(OP_CMD, CMD_PROG_SETUP, ERR_NONE);
    ex(OP_ADDR, 8'h00, ERR_NONE);
    ex(OP_ADDR, 8'h00, ERR_NONE);
    ex(OP_ADDR, 8'h00, ERR_NONE);
    ex(OP_ADDR, 8'h42, ERR_NONE);
    ex(OP_DATA_IN, 8'h5a, ERR_NONE);
    ex(OP_CMD, CMD_CACHE_PROG_CONFIRM, ERR_NONE);
    chk_val(16'(ready_busy_n), 16'h0000);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    prog(16'h0077, ERR_NONE);
    chk_val(16'(ready_busy_n), 16'h0000);
    ex(OP_WAIT_READY, 8'h00, ERR_NONE);
    prog(16'h0055, ERR_NONE);
    @(posedge mclk);
    write_allow <= 1'b0;
    repeat (3) @(negedge mclk);
    chk_val(16'(ready_busy_n), 16'h0001);
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_wp_low();
    t_program();
    t_limit();
    t_prot_block();
    t_reset_busy();
    t_busy_kinds();
    results();
  end
endmodule

`default_nettype wire
